/* endpoint_buffer_command_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - interrupt bit 15 flags a hub device status change
// - bits 14, 13, 12 flag port changes of functions 3, 2, 1
// - four bits per function: ep1 in, ep1 out, ctrl in, ctrl out
// - reading hub device status clears bit 15
// - reading an embedded port status clears its change bit
// - select-and-clear command clears the selected endpoint's bits
// - codes 00..0b select endpoint 0..11, pointer to buffer start
// - one optional read after select returns the buffer state byte
// - state bit 0 is full/empty, bits 7..5 reserved
// - state bit 1 shows the endpoint is halted
// - state bit 2: last rx was setup, cleared by select-clear, 0 for in
// - state bit 3: setup overwrote packet, cleared by select-clear only
// - state bit 4 set on nak, cleared on ack either direction
// - nak bit only for control endpoints and when nak irq enabled
// - read buffer command f0 streams selected buffer, up to n+2 bytes
// - each buffer byte advances pointer; only select rewinds it
// - other commands pause a transfer, pointer kept for resume
// - byte 0: bit 7 received ok, bit 6 setup token
// - byte 1 holds data count, data from byte 2 onward
// - write buffer shares code f0, same layout, up to n+2 bytes
// - command f4 then two reads, low byte then high byte
// - config bit 0 set makes a nak raise an interrupt
// - codes 40..4b select-and-clear, a read returns state byte
module endpoint_buffer_command_port (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // microcontroller command port
    input wire ep_cmd_pkg::uc_req_s i_uc,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    output logic o_irq,
    // configuration and status-register read events
    input wire logic i_irq_on_negative_ack,
    input wire logic i_hub_state_changed,
    input wire logic i_hub_status_read,
    input wire logic [2:0] i_embedded_port_changed,
    input wire logic [2:0] i_embedded_port_read,
    // serial engine side
    input wire ep_cmd_pkg::sie_event_s i_sie_evt,
    input wire logic [11:0] i_ep_full,
    input wire logic [11:0] i_ep_halted,
    input wire ep_cmd_pkg::sie_mem_s i_sie_mem,
    output logic [7:0] o_sie_rdata
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // endpoint order per function: ctrl out, ctrl in, ep1 out, ep1 in
    function automatic logic ep_is_ctrl(input logic [3:0] ep);
        ep_is_ctrl = ~ep[1];
    endfunction : ep_is_ctrl

    function automatic logic ep_is_in(input logic [3:0] ep);
        ep_is_in = ep[0];
    endfunction : ep_is_in

    function automatic logic ep_valid(input logic [3:0] ep);
        ep_valid = (32'(ep) < ep_cmd_pkg::NUM_EP);
    endfunction : ep_valid

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ep_cmd_pkg::cmd_state_e state_ff;
    ep_cmd_pkg::rd_src_e rd_src_ff;
    logic rd_pend_ff;
    logic [3:0] sel_ff;
    logic [4:0] ptr_ff;
    logic [15:0] irq_ff;
    logic [15:0] nxt_irq;
    logic [15:0] irq_set;
    logic [15:0] irq_clr;
    logic [11:0] setup_ff;
    logic [11:0] clobber_ff;
    logic [11:0] nak_ff;
    logic [7:0] state_hold_ff;
    logic [7:0] ram_q;
    logic [7:0] nxt_rdata;
    logic cmd_select;
    logic cmd_selclr;
    logic [3:0] cmd_ep;
    logic buf_rd;
    logic buf_wr;
    logic [11:0] evt_onehot;
    logic [11:0] selclr_onehot;
    logic evt_hit;
    logic nak_counts;
    logic [4:0] sie_slot;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign cmd_ep = i_uc.data[3:0];
    assign cmd_select = i_uc.cmd_we &&
        (i_uc.data >= ep_cmd_pkg::CMD_SELECT_FIRST) &&
        (i_uc.data <= ep_cmd_pkg::CMD_SELECT_LAST);
    assign cmd_selclr = i_uc.cmd_we &&
        (i_uc.data >= ep_cmd_pkg::CMD_SELCLR_FIRST) &&
        (i_uc.data <= ep_cmd_pkg::CMD_SELCLR_LAST);
    // a command in the same cycle outranks a data strobe
    assign buf_rd = i_uc.rd_req && !i_uc.cmd_we &&
        (state_ff == ep_cmd_pkg::CS_BUFFER);
    assign buf_wr = i_uc.wr_req && !i_uc.cmd_we && !i_uc.rd_req &&
        (state_ff == ep_cmd_pkg::CS_BUFFER);

    // one-hot views of the event endpoint and the cleared endpoint
    assign evt_hit = i_sie_evt.valid && ep_valid(i_sie_evt.ep);
    assign evt_onehot = evt_hit ? 12'(12'h001 << i_sie_evt.ep) : 12'h000;
    assign selclr_onehot = cmd_selclr ? 12'(12'h001 << cmd_ep) : 12'h000;

    // nak only counts on control endpoints with the option on
    assign nak_counts = i_sie_evt.nak && i_irq_on_negative_ack &&
        ep_is_ctrl(i_sie_evt.ep);

    // ------------------------------------------------------------
    // command state and selection
    // ------------------------------------------------------------
    // any other command simply moves state; the pointer is untouched
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= ep_cmd_pkg::CS_IDLE;
        end else if (i_uc.cmd_we) begin
            if (cmd_select || cmd_selclr) begin
                state_ff <= ep_cmd_pkg::CS_STATUS;
            end else if (i_uc.data == ep_cmd_pkg::CMD_BUFFER) begin
                state_ff <= ep_cmd_pkg::CS_BUFFER;
            end else if (i_uc.data == ep_cmd_pkg::CMD_READ_IRQ) begin
                state_ff <= ep_cmd_pkg::CS_IRQ_LO;
            end else begin
                state_ff <= ep_cmd_pkg::CS_IDLE;
            end
        end else if (i_uc.rd_req) begin
            unique case (state_ff)
                ep_cmd_pkg::CS_STATUS: state_ff <= ep_cmd_pkg::CS_IDLE;
                ep_cmd_pkg::CS_IRQ_LO: state_ff <= ep_cmd_pkg::CS_IRQ_HI;
                ep_cmd_pkg::CS_IRQ_HI: state_ff <= ep_cmd_pkg::CS_IDLE;
                ep_cmd_pkg::CS_BUFFER: state_ff <= ep_cmd_pkg::CS_BUFFER;
                ep_cmd_pkg::CS_IDLE: state_ff <= ep_cmd_pkg::CS_IDLE;
            endcase
        end
    end

    // selected endpoint
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sel_ff <= 4'h0;
        end else if (cmd_select || cmd_selclr) begin
            sel_ff <= cmd_ep;
        end
    end

    // buffer pointer: select rewinds, each buffer byte advances it
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ptr_ff <= ep_cmd_pkg::HEAD_SLOT;
        end else if (cmd_select) begin
            ptr_ff <= ep_cmd_pkg::HEAD_SLOT;
        end else if (buf_rd || buf_wr) begin
            // no bound check: wraps inside the slot, caller stays in range
            ptr_ff <= 5'(ptr_ff + 5'h01);
        end
    end

    // ------------------------------------------------------------
    // interrupt source register
    // ------------------------------------------------------------
    always_comb begin
        irq_set = ep_cmd_pkg::IRQ_RESET;
        irq_clr = ep_cmd_pkg::IRQ_RESET;
        irq_set[ep_cmd_pkg::IRQ_HUB_BIT] = i_hub_state_changed;
        irq_clr[ep_cmd_pkg::IRQ_HUB_BIT] = i_hub_status_read;
        for (int f = 0; f < ep_cmd_pkg::NUM_FUNC; f++) begin
            // function 1 at bit 12 up to function 3 at bit 14
            irq_set[ep_cmd_pkg::IRQ_PORT_BASE + f] =
                i_embedded_port_changed[f];
            irq_clr[ep_cmd_pkg::IRQ_PORT_BASE + f] =
                i_embedded_port_read[f];
        end
        // endpoint index equals its bit: four bits per function
        if (i_sie_evt.rx_ok || i_sie_evt.tx_ok || nak_counts) begin
            irq_set[11:0] = evt_onehot;
        end
        irq_clr[11:0] = selclr_onehot;
    end

    // set wins over a same-cycle clear so no event is lost
    assign nxt_irq = (irq_ff & ~irq_clr) | irq_set;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            irq_ff <= ep_cmd_pkg::IRQ_RESET;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // request stays up while anything is pending
    assign o_irq = |irq_ff;

    // ------------------------------------------------------------
    // per-endpoint status flags
    // ------------------------------------------------------------
    // setup flag tracks the last good rx; in buffers never get it
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            setup_ff <= ep_cmd_pkg::EP_FLAGS_RESET;
        end else begin
            setup_ff <= (setup_ff & ~selclr_onehot &
                ~(i_sie_evt.rx_ok ? evt_onehot : 12'h000)) |
                ((i_sie_evt.rx_ok && i_sie_evt.setup &&
                !ep_is_in(i_sie_evt.ep)) ? evt_onehot : 12'h000);
        end
    end

    // overwrite flag: only select-and-clear removes it
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            clobber_ff <= ep_cmd_pkg::EP_FLAGS_RESET;
        end else begin
            clobber_ff <= (clobber_ff & ~selclr_onehot) |
                (i_sie_evt.clobber ? evt_onehot : 12'h000);
        end
    end

    // nak flag: set on nak, dropped on an ack in either direction
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            nak_ff <= ep_cmd_pkg::EP_FLAGS_RESET;
        end else begin
            nak_ff <= (nak_ff & ~((i_sie_evt.rx_ok || i_sie_evt.tx_ok) ?
                evt_onehot : 12'h000)) |
                (nak_counts ? evt_onehot : 12'h000);
        end
    end

    // snapshot at command time so select-clear still shows old flags
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_hold_ff <= 8'h00;
        end else if ((cmd_select || cmd_selclr) && ep_valid(cmd_ep)) begin
            state_hold_ff <= 8'h00;
            state_hold_ff[ep_cmd_pkg::ST_OCCUPIED_BIT] <=
                i_ep_full[cmd_ep];
            state_hold_ff[ep_cmd_pkg::ST_HALTED_BIT] <=
                i_ep_halted[cmd_ep];
            state_hold_ff[ep_cmd_pkg::ST_SETUP_BIT] <=
                setup_ff[cmd_ep] && !ep_is_in(cmd_ep);
            state_hold_ff[ep_cmd_pkg::ST_CLOBBER_BIT] <=
                clobber_ff[cmd_ep];
            state_hold_ff[ep_cmd_pkg::ST_NAK_BIT] <= nak_ff[cmd_ep];
        end else if (cmd_select || cmd_selclr) begin
            state_hold_ff <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // endpoint buffer storage
    // ------------------------------------------------------------
    // engine addresses data by index; count sits at byte 1
    assign sie_slot = i_sie_mem.len_we ? ep_cmd_pkg::LEN_SLOT :
        5'(i_sie_mem.idx + ep_cmd_pkg::DATA_SLOT);

    ep_buffer_ram #(
        .AW(ep_cmd_pkg::RAM_AW),
        .DW(ep_cmd_pkg::BYTE_W)
    ) u_ram (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_a_we(buf_wr),
        .i_a_addr({sel_ff, ptr_ff}),
        .i_a_wdata(i_uc.data),
        .o_a_rdata(ram_q),
        .i_b_we(i_sie_mem.we || i_sie_mem.len_we),
        .i_b_addr({i_sie_mem.ep, sie_slot}),
        .i_b_wdata(i_sie_mem.data),
        .o_b_rdata(o_sie_rdata)
    );

    // ------------------------------------------------------------
    // read pipeline: taken at cycle 0, answer valid in cycle 2
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rd_pend_ff <= 1'b0;
            rd_src_ff <= ep_cmd_pkg::RS_NONE;
        end else begin
            rd_pend_ff <= i_uc.rd_req && !i_uc.cmd_we;
            unique case (state_ff)
                ep_cmd_pkg::CS_STATUS: rd_src_ff <= ep_cmd_pkg::RS_STATUS;
                ep_cmd_pkg::CS_IRQ_LO: rd_src_ff <= ep_cmd_pkg::RS_IRQ_LO;
                ep_cmd_pkg::CS_IRQ_HI: rd_src_ff <= ep_cmd_pkg::RS_IRQ_HI;
                ep_cmd_pkg::CS_BUFFER: rd_src_ff <=
                    (ptr_ff == ep_cmd_pkg::HEAD_SLOT) ?
                    ep_cmd_pkg::RS_HEAD : ep_cmd_pkg::RS_BUF;
                ep_cmd_pkg::CS_IDLE: rd_src_ff <= ep_cmd_pkg::RS_NONE;
            endcase
        end
    end

    // answer mux; header byte carries live rx-ok and setup flags
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (rd_src_ff)
            ep_cmd_pkg::RS_STATUS: nxt_rdata = state_hold_ff;
            ep_cmd_pkg::RS_IRQ_LO: nxt_rdata = irq_ff[7:0];
            ep_cmd_pkg::RS_IRQ_HI: nxt_rdata = irq_ff[15:8];
            ep_cmd_pkg::RS_BUF: nxt_rdata = ram_q;
            ep_cmd_pkg::RS_HEAD: begin
                nxt_rdata = ram_q;
                nxt_rdata[ep_cmd_pkg::HEAD_RX_OK_BIT] =
                    ep_valid(sel_ff) && i_ep_full[sel_ff] &&
                    !ep_is_in(sel_ff);
                nxt_rdata[ep_cmd_pkg::HEAD_SETUP_BIT] =
                    ep_valid(sel_ff) && setup_ff[sel_ff];
            end
            ep_cmd_pkg::RS_NONE: nxt_rdata = 8'h00;
        endcase
    end

    // data register holds the last answer until the next one
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= rd_pend_ff;
            if (rd_pend_ff) begin
                o_rdata <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    hub_change_set_a: assert property (
        i_hub_state_changed |=> irq_ff[15] && o_irq)
        else $error("hub change did not set bit 15");

    port_change_set_a: assert property (
        i_embedded_port_changed[1] |=> irq_ff[13])
        else $error("function 2 port change did not set bit 13");

    ep_event_bit_a: assert property (
        evt_hit && i_sie_evt.rx_ok |=> irq_ff[$past(i_sie_evt.ep)])
        else $error("endpoint event did not set its own bit");

    hub_read_clear_a: assert property (
        i_hub_status_read && !i_hub_state_changed |=> !irq_ff[15])
        else $error("hub status read did not clear bit 15");

    port_read_clear_a: assert property (
        i_embedded_port_read[0] && !i_embedded_port_changed[0]
        |=> !irq_ff[12])
        else $error("port status read did not clear bit 12");

    selclr_clear_a: assert property (
        cmd_selclr && !i_sie_evt.valid |=> !irq_ff[sel_ff])
        else $error("select-clear left endpoint bit set");

    select_rewind_a: assert property (
        cmd_select |=> ptr_ff == 5'h00 && sel_ff == $past(cmd_ep))
        else $error("select did not rewind pointer");

    status_answer_a: assert property (
        cmd_select ##[1:2] (i_uc.rd_req && !i_uc.cmd_we)
        |-> ##2 o_rd_valid && o_rdata[7:5] == 3'h0)
        else $error("state byte answer missing or reserved bits set");

    read_latency_a: assert property (
        i_uc.rd_req && !i_uc.cmd_we |-> ##2 o_rd_valid)
        else $error("read answer not in cycle 2");

    ptr_advance_a: assert property (
        buf_rd || buf_wr |=> ptr_ff == 5'($past(ptr_ff) + 5'h01))
        else $error("buffer byte did not advance pointer");

    ptr_kept_a: assert property (
        i_uc.cmd_we && !cmd_select |=> $stable(ptr_ff))
        else $error("other command moved the pointer");

    irq_low_then_high_a: assert property (
        i_uc.cmd_we && i_uc.data == 8'hf4 ##[1:2]
        (i_uc.rd_req && !i_uc.cmd_we) |=> rd_src_ff == ep_cmd_pkg::RS_IRQ_LO)
        else $error("first read after f4 not the low byte");

    irq_drop_a: assert property (
        $fell(o_irq) |-> $past(irq_clr) != 16'h0000)
        else $error("interrupt dropped without a clear");

endmodule : endpoint_buffer_command_port

`default_nettype wire

/* ep_cmd_pkg.sv */
package ep_cmd_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_EP = 12;
    localparam int EP_W = 4;
    localparam int SLOT_W = 5;
    localparam int BYTE_W = 8;
    localparam int IRQ_W = 16;
    localparam int RAM_AW = EP_W + SLOT_W;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SELECT_FIRST = 8'h00;
    localparam logic [7:0] CMD_SELECT_LAST = 8'h0b;
    localparam logic [7:0] CMD_SELCLR_FIRST = 8'h40;
    localparam logic [7:0] CMD_SELCLR_LAST = 8'h4b;
    localparam logic [7:0] CMD_BUFFER = 8'hf0;
    localparam logic [7:0] CMD_READ_IRQ = 8'hf4;

    // ------------------------------------------------------------
    // interrupt source layout and reset
    // ------------------------------------------------------------
    localparam int IRQ_HUB_BIT = 15;
    localparam int IRQ_PORT_BASE = 12;
    localparam int NUM_FUNC = 3;
    localparam logic [15:0] IRQ_RESET = 16'h0000;

    // ------------------------------------------------------------
    // endpoint buffer state byte layout
    // ------------------------------------------------------------
    localparam int ST_OCCUPIED_BIT = 0;
    localparam int ST_HALTED_BIT = 1;
    localparam int ST_SETUP_BIT = 2;
    localparam int ST_CLOBBER_BIT = 3;
    localparam int ST_NAK_BIT = 4;
    localparam logic [11:0] EP_FLAGS_RESET = 12'h000;

    // ------------------------------------------------------------
    // buffer layout: header byte, length byte, then data
    // ------------------------------------------------------------
    localparam logic [4:0] HEAD_SLOT = 5'h00;
    localparam logic [4:0] LEN_SLOT = 5'h01;
    localparam logic [4:0] DATA_SLOT = 5'h02;
    localparam int HEAD_RX_OK_BIT = 7;
    localparam int HEAD_SETUP_BIT = 6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_IDLE, CS_STATUS, CS_IRQ_LO, CS_IRQ_HI, CS_BUFFER
    } cmd_state_e;

    typedef enum logic [2:0] {
        RS_NONE, RS_STATUS, RS_IRQ_LO, RS_IRQ_HI, RS_BUF, RS_HEAD
    } rd_src_e;

    // microcontroller side: one request per cycle
    typedef struct packed {
        logic cmd_we;
        logic rd_req;
        logic wr_req;
        logic [7:0] data;
    } uc_req_s;

    // serial engine transaction report
    typedef struct packed {
        logic valid;
        logic rx_ok;
        logic tx_ok;
        logic setup;
        logic clobber;
        logic nak;
        logic [3:0] ep;
    } sie_event_s;

    // serial engine buffer port
    typedef struct packed {
        logic we;
        logic len_we;
        logic [3:0] ep;
        logic [4:0] idx;
        logic [7:0] data;
    } sie_mem_s;

endpackage : ep_cmd_pkg

/* ep_buffer_ram.sv */
`timescale 1ns/1ps
`default_nettype none

module ep_buffer_ram #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // port a
    input wire logic i_a_we,
    input wire logic [AW-1:0] i_a_addr,
    input wire logic [DW-1:0] i_a_wdata,
    output logic [DW-1:0] o_a_rdata,
    // port b
    input wire logic i_b_we,
    input wire logic [AW-1:0] i_b_addr,
    input wire logic [DW-1:0] i_b_wdata,
    output logic [DW-1:0] o_b_rdata
);

    logic [DW-1:0] mem_ff [2**AW];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // port b written last so the engine wins a same-address clash
    always_ff @(posedge i_mclk) begin
        if (i_a_we) begin
            mem_ff[i_a_addr] <= i_a_wdata;
        end
        if (i_b_we) begin
            mem_ff[i_b_addr] <= i_b_wdata;
        end
    end

    // registered read data on both ports
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_a_rdata <= '0;
            o_b_rdata <= '0;
        end else begin
            o_a_rdata <= mem_ff[i_a_addr];
            o_b_rdata <= mem_ff[i_b_addr];
        end
    end

endmodule : ep_buffer_ram

`default_nettype wire

/* uc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// microcontroller side of the command port
// ----------------------------------------
module uc_model (
    // clock
    input wire logic i_mclk,
    // command port
    output var ep_cmd_pkg::uc_req_s o_uc,
    input wire logic [7:0] i_rdata,
    input wire logic i_rd_valid
);
    // idle port; every task starts just after a falling edge
    initial o_uc = '0;

    // command byte, one cycle
    // one idle cycle after each strobe so no edge sees two writes
    task automatic cmd(input logic [7:0] c);
        o_uc = '{1'b1, 1'b0, 1'b0, c};
        @(negedge i_mclk) o_uc = '0;
        @(negedge i_mclk);
    endtask : cmd

    // write byte; header must be zero
    task automatic wr(input logic [7:0] b);
        o_uc = '{1'b0, 1'b0, 1'b1, b};
        @(negedge i_mclk) o_uc = '0;
        @(negedge i_mclk);
    endtask : wr

    // answer valid in cycle 2 only, so a late one reads as x
    task automatic rd(output logic [7:0] b);
        o_uc = '{1'b0, 1'b1, 1'b0, 8'h00};
        @(negedge i_mclk) o_uc = '0;
        @(negedge i_mclk);
        b = i_rd_valid ? i_rdata : 8'hxx;
    endtask : rd
endmodule : uc_model

`default_nettype wire

/* endpoint_buffer_command_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module endpoint_buffer_command_port_tb_top;
    logic i_mclk = 0, i_reset = 1, nak_on = 1, hub_chg = 0, hub_rd = 0;
    logic [2:0] port_chg = 0, port_rd = 0;
    logic [11:0] full = 12'h001, halted = 12'h001;
    logic [7:0] rdata, d, sie_rd;
    ep_cmd_pkg::sie_mem_s sie_mem = '0;
    logic rd_valid, irq;
    ep_cmd_pkg::sie_event_s evt = '0;
    ep_cmd_pkg::uc_req_s uc;
    int miscompares = 0, tests_run = 0;

    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    initial forever #20 i_mclk = ~i_mclk;
    uc_model u (.i_mclk(i_mclk), .o_uc(uc), .i_rdata(rdata),
        .i_rd_valid(rd_valid));
    endpoint_buffer_command_port dut (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_uc(uc), .o_rdata(rdata), .o_rd_valid(rd_valid), .o_irq(irq),
        .i_irq_on_negative_ack(nak_on), .i_hub_state_changed(hub_chg),
        .i_hub_status_read(hub_rd), .i_embedded_port_changed(port_chg),
        .i_embedded_port_read(port_rd), .i_sie_evt(evt), .i_ep_full(full),
        .i_ep_halted(halted), .i_sie_mem(sie_mem), .o_sie_rdata(sie_rd));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one engine report pulse
    task automatic ev(input ep_cmd_pkg::sie_event_s e);
        evt = e;
        @(negedge i_mclk) evt = '0;
        @(negedge i_mclk);
    endtask : ev

    // interrupt source, low byte then high byte
    task automatic irq_rd(input logic [15:0] exp);
        u.cmd(ep_cmd_pkg::CMD_READ_IRQ);
        u.rd(d);
        chk(d, exp[7:0]);
        u.rd(d);
        chk(d, exp[15:8]);
    endtask : irq_rd

    // select or select-clear, then its state byte
    task automatic sel(input logic [7:0] c, input logic [7:0] exp);
        u.cmd(c);
        u.rd(d);
        chk(d, exp);
    endtask : sel

    task automatic final_report;
        $display("mismatches %0d of %0d checks", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge i_mclk);
        i_reset = 0;
        chk({7'h0, irq}, 8'h00);
        ev('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0});
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0});
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h4});
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h2});
        ev('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5});
        hub_chg = 1;
        port_chg = 3'h4;
        @(negedge i_mclk);
        hub_chg = 0;
        port_chg = 0;
        chk({7'h0, irq}, 8'h01);
        irq_rd(16'hc031);
        hub_rd = 1;
        port_rd = 3'h4;
        @(negedge i_mclk);
        hub_rd = 0;
        port_rd = 0;
        irq_rd(16'h0031);
        sel(8'h02, 8'h00);
        sel(8'h00, 8'h1f);
        sel(8'h40, 8'h1f);
        sel(8'h00, 8'h13);
        nak_on = 0;
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h8});
        irq_rd(16'h0030);
        u.cmd(8'h44);
        u.cmd(8'h45);
        chk({7'h0, irq}, 8'h00);
        // fill an in buffer, then read it back with a pause in the middle
        u.cmd(8'h03);
        u.cmd(ep_cmd_pkg::CMD_BUFFER);
        u.wr(8'h00);
        u.wr(8'h02);
        u.wr(8'haa);
        u.wr(8'h5b);
        sel(8'h03, 8'h00);
        u.cmd(ep_cmd_pkg::CMD_BUFFER);
        u.rd(d);
        chk(d, 8'h00);
        u.rd(d);
        chk(d, 8'h02);
        irq_rd(16'h0000);
        u.cmd(ep_cmd_pkg::CMD_BUFFER);
        u.rd(d);
        chk(d, 8'haa);
        u.rd(d);
        chk(d, 8'h5b);
        // engine fills out endpoint 2: count then one data byte
        sie_mem = '{1'b0, 1'b1, 4'h2, 5'h00, 8'h01};
        @(negedge i_mclk) sie_mem = '{1'b1, 1'b0, 4'h2, 5'h00, 8'h3c};
        @(negedge i_mclk) sie_mem = '{1'b0, 1'b0, 4'h2, 5'h00, 8'h00};
        full = 12'h005;
        halted = 12'h004;
        @(negedge i_mclk);
        chk(sie_rd, 8'h3c);
        sel(8'h02, 8'h03);
        u.cmd(ep_cmd_pkg::CMD_BUFFER);
        u.rd(d);
        chk({7'h0, d[7]}, 8'h01);
        u.rd(d);
        chk(d, 8'h01);
        u.rd(d);
        chk(d, 8'h3c);
        final_report();
    end

    // watchdog after 4000 cycles: the tests need well under that
    initial begin
        #160000;
        miscompares++;
        final_report();
    end
endmodule : endpoint_buffer_command_port_tb_top

`default_nettype wire
